// File: design/dgpio_pkg.sv
// package: register offsets, config fields, reset values and carrier types for the dual group io
`default_nettype none
package dgpio_pkg;
  // window geometry
  localparam int unsigned DGPIO_ADDR_W = 10;          // host i/o address width
  localparam logic [5:0] DGPIO_BASE_DEFAULT = 6'h30;  // base 0x300, a9..a4
  localparam int unsigned DGPIO_BASE_LSB = 4;         // switches compare a9..a4
  // register offsets inside the 16-location window
  localparam logic [3:0] DGPIO_OFS_PA0 = 4'h0;
  localparam logic [3:0] DGPIO_OFS_PB0 = 4'h1;
  localparam logic [3:0] DGPIO_OFS_PC0 = 4'h2;
  localparam logic [3:0] DGPIO_OFS_CFG0 = 4'h3;
  localparam logic [3:0] DGPIO_OFS_PA1 = 4'h4;
  localparam logic [3:0] DGPIO_OFS_PB1 = 4'h5;
  localparam logic [3:0] DGPIO_OFS_PC1 = 4'h6;
  localparam logic [3:0] DGPIO_OFS_CFG1 = 4'h7;
  localparam logic [3:0] DGPIO_OFS_DIR = 4'h8;
  localparam logic [3:0] DGPIO_OFS_GATE = 4'h9;
  // configuration word fields
  localparam logic [2:0] DGPIO_CFG_TAG = 3'h4;        // bits 7-5 must be 100
  localparam int unsigned DGPIO_CFG_A_BIT = 4;
  localparam int unsigned DGPIO_CFG_CH_BIT = 3;
  localparam int unsigned DGPIO_CFG_B_BIT = 1;
  localparam int unsigned DGPIO_CFG_CL_BIT = 0;
  // port index layout inside six-bit mode vectors: a0,b0,c0 then a1,b1,c1
  localparam int unsigned DGPIO_NPORT = 6;
  localparam logic [5:0] DGPIO_INPUT_ALL = 6'h3f;     // reset: all inputs
  localparam logic [5:0] DGPIO_DIR_RST = 6'h00;
  localparam logic [5:0] DGPIO_GATE_RST = 6'h00;
  localparam logic [7:0] DGPIO_UNDEF_READ = 8'hff;    // write-only / unused offset read
  localparam int unsigned DGPIO_SRC_BIT = 0;          // port c bit that raises interrupts
  localparam int unsigned DGPIO_GATE_BIT = 4;         // port c bit that gates them
  localparam logic [2:0] DGPIO_IRQ_LVL_MIN = 3'h2;
  localparam logic [2:0] DGPIO_IRQ_LVL_MAX = 3'h7;
  localparam logic [2:0] DGPIO_IRQ_LVL_DEF = 3'h5;

  // interrupt mode jumper encoding
  typedef enum logic [1:0] {
    DGPIO_MODE_OFF = 2'b00,
    DGPIO_MODE_ON = 2'b01,
    DGPIO_MODE_GATED = 2'b10
  } dgpio_mode_t;

  // per-source interrupt configuration
  typedef struct packed {
    logic [2:0] level;    // host request level 2..7
    logic falling;        // 0 rising, 1 falling
    dgpio_mode_t mode;
  } dgpio_irq_cfg_t;

  // host bus request
  typedef struct packed {
    logic [DGPIO_ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dgpio_bus_req_t;
endpackage
`default_nettype wire

// File: design/dgpio_irq_edge.sv
// one interrupt source: synchroniser, edge select, mode gating and level steering
`default_nettype none
module dgpio_irq_edge
  import dgpio_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic src_in,
  input wire logic gate_in,
  input wire dgpio_irq_cfg_t cfg_in,
  output logic [7:2] irq_out
);
  logic meta_r;     // first synchroniser stage
  logic sync_r;     // second stage
  logic last_r;     // previous synchronised level
  logic gate_s1_r;  // gate line first stage
  logic gate_r;     // gate line synchronised
  logic edge_hit;
  logic allow;

  // two-flop synchronisers, edge history
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      gate_s1_r <= 1'b1;
      gate_r <= 1'b1;
    end else if (clk_en_in) begin
      meta_r <= src_in;
      sync_r <= meta_r;
      last_r <= sync_r;
      gate_s1_r <= gate_in;
      gate_r <= gate_s1_r;
    end
  end

  // qualifying edge and mode gate
  always_comb begin
    edge_hit = cfg_in.falling ? (last_r & ~sync_r)
                              : (~last_r & sync_r);
    case (cfg_in.mode)
      DGPIO_MODE_ON: allow = 1'b1;
      DGPIO_MODE_GATED: allow = ~gate_r;
      default: allow = 1'b0;
    endcase
  end

  // one pulse per edge onto the selected level
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq_out <= '0;
    end else if (clk_en_in) begin
      irq_out <= '0;
      if (edge_hit && allow && cfg_in.level >= DGPIO_IRQ_LVL_MIN) begin
        irq_out[cfg_in.level] <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: design/dgpio_top.sv
// dual group parallel io: host window decode, six ports, buffer control, two interrupts
`default_nettype none
//
// Contract
// - six eight-bit ports, two groups of three
// - each port individually input or output
// - claim sixteen addresses, ignore all others
// - switches compare address lines a9..a4
// - base selectable 000 to 3f0 step 16
// - default base setting is 300
// - ten locations decoded at offsets 0..9
// - group-0 config write-only, reads undefined
// - group-1 config, direction, gate write-only
// - plain reads and writes, no handshake
// - outputs latched, inputs read live
// - port c direction set as whole
// - bit 7 maps highest line
// - port c bit 0 interrupt source
// - each source routed to level 2..7
// - per-source rising or falling, rising default
// - rising mode fires on low-to-high
// - falling mode fires on high-to-low
// - off mode suppresses all interrupts
// - always-on mode fires on every selected edge
// - group-0 port c bit 4 low enables
// - group-1 port c bit 4 gates likewise
// - config word 100 tag, a/c/b bits
// - reset makes all six ports inputs
// - direction bit 1 drives outward
// - gate bit 1 activates; reset clears both
module dgpio_top
  import dgpio_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,                   // low freezes all state
  input wire logic [5:0] base_select_switch_in, // a9..a4 match value
  input wire dgpio_bus_req_t bus_req_in,        // host i/o cycle
  input wire dgpio_irq_cfg_t irq_cfg0_in,       // source 0 jumpers
  input wire dgpio_irq_cfg_t irq_cfg1_in,       // source 1 jumpers
  input wire logic [47:0] pin_in,               // pin levels, port 0 in bits 7:0
  output logic [47:0] pin_out,                  // latched drive values
  output logic [47:0] pin_oe_n_out,             // low while driving a line
  output logic [5:0] buf_dir_out,               // external buffer direction
  output logic [5:0] buf_gate_out,              // external buffer active
  output logic [7:0] rdata_out,                 // host read data
  output logic rdata_valid_out,                 // read answered this cycle
  output logic sel_out,                         // window selected
  output logic [7:2] irq_out                    // host request levels
);
  logic [7:0] latch_r [DGPIO_NPORT];  // output latches per port
  logic [5:0] in_mode_r;              // 1 = port is input
  logic [5:0] dir_r;                  // buffer direction register
  logic [5:0] gate_r;                 // buffer gate register
  logic hit;                          // address inside window
  logic [3:0] ofs;                    // offset inside window
  logic [7:2] irq0;
  logic [7:2] irq1;
  logic [7:0] rd_nxt;
  logic [47:0] oe_n_nxt;
  logic [47:0] pin_nxt;

  // map a window offset to a data port index, or 7 when not a data port
  // offsets 3, 7, 8 and 9 are the write-only control words, handled apart
  function automatic logic [2:0] port_idx(input logic [3:0] o);
    if (o == DGPIO_OFS_PA0) begin
      port_idx = 3'd0;
    end else if (o == DGPIO_OFS_PB0) begin
      port_idx = 3'd1;
    end else if (o == DGPIO_OFS_PC0) begin
      port_idx = 3'd2;
    end else if (o == DGPIO_OFS_PA1) begin
      port_idx = 3'd3;
    end else if (o == DGPIO_OFS_PB1) begin
      port_idx = 3'd4;
    end else if (o == DGPIO_OFS_PC1) begin
      port_idx = 3'd5;
    end else begin
      port_idx = 3'd7;
    end
  endfunction

  // decode a configuration word into input flags for a, b, c
  function automatic logic [2:0] cfg_modes(input logic [7:0] w);
    // c takes the upper-half bit; both c bits describe one unit
    cfg_modes = {w[DGPIO_CFG_CH_BIT], w[DGPIO_CFG_B_BIT], w[DGPIO_CFG_A_BIT]};
  endfunction

  // window decode: six switches against a9..a4
  // the switches leave the factory at DGPIO_BASE_DEFAULT, base 0x300
  always_comb begin
    hit = (bus_req_in.addr[DGPIO_ADDR_W-1:DGPIO_BASE_LSB] == base_select_switch_in);
    ofs = bus_req_in.addr[DGPIO_BASE_LSB-1:0];
  end

  // data port latches: written values held until rewritten
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < DGPIO_NPORT; i++) begin
        latch_r[i] <= 8'h00;
      end
    end else if (clk_en_in && hit && bus_req_in.wr && port_idx(ofs) != 3'd7) begin
      latch_r[port_idx(ofs)] <= bus_req_in.wdata;
    end
  end

  // port mode words; malformed tag ignored
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      in_mode_r <= DGPIO_INPUT_ALL;
    end else if (clk_en_in && hit && bus_req_in.wr
                 && bus_req_in.wdata[7:5] == DGPIO_CFG_TAG) begin
      if (ofs == DGPIO_OFS_CFG0) begin
        in_mode_r[2:0] <= cfg_modes(bus_req_in.wdata);
      end else if (ofs == DGPIO_OFS_CFG1) begin
        in_mode_r[5:3] <= cfg_modes(bus_req_in.wdata);
      end
    end
  end

  // buffer direction and gate registers, bits 0..5 = a0,b0,c0,c1,b1,a1
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      dir_r <= DGPIO_DIR_RST;
      gate_r <= DGPIO_GATE_RST;
    end else if (clk_en_in && hit && bus_req_in.wr) begin
      if (ofs == DGPIO_OFS_DIR) begin
        dir_r <= bus_req_in.wdata[5:0];
      end else if (ofs == DGPIO_OFS_GATE) begin
        gate_r <= bus_req_in.wdata[5:0];
      end
    end
  end

  // read mux and pin drive; ports live when input, latched when output
  always_comb begin
    logic [2:0] pi;
    logic [2:0] bi;
    bi = 3'd0;
    pi = port_idx(ofs);
    rd_nxt = DGPIO_UNDEF_READ;
    if (pi != 3'd7) begin
      rd_nxt = in_mode_r[pi] ? pin_in[8*pi +: 8] : latch_r[pi];
    end
    for (int p = 0; p < DGPIO_NPORT; p++) begin
      // register bits run a0,b0,c0 then c1,b1,a1
      bi = (p < 3) ? 3'(p) : 3'(8 - p);
      pin_nxt[8*p +: 8] = latch_r[p];
      oe_n_nxt[8*p +: 8] = {8{~(~in_mode_r[p] & dir_r[bi] & gate_r[bi])}};
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rdata_out <= 8'h00;
      rdata_valid_out <= 1'b0;
      sel_out <= 1'b0;
      pin_out <= '0;
      pin_oe_n_out <= '1;
      buf_dir_out <= DGPIO_DIR_RST;
      buf_gate_out <= DGPIO_GATE_RST;
    end else if (clk_en_in) begin
      sel_out <= hit;
      rdata_valid_out <= hit && bus_req_in.rd;
      rdata_out <= (hit && bus_req_in.rd) ? rd_nxt : 8'h00;
      pin_out <= pin_nxt;
      pin_oe_n_out <= oe_n_nxt;
      buf_dir_out <= dir_r;
      buf_gate_out <= gate_r;
    end
  end

  // group-0 interrupt source, port c bit 0 with bit 4 gate
  dgpio_irq_edge u_irq0 (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .src_in(pin_in[16 + DGPIO_SRC_BIT]),
    .gate_in(pin_in[16 + DGPIO_GATE_BIT]),
    .cfg_in(irq_cfg0_in),
    .irq_out(irq0)
  );

  // group-1 interrupt source
  dgpio_irq_edge u_irq1 (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .src_in(pin_in[40 + DGPIO_SRC_BIT]),
    .gate_in(pin_in[40 + DGPIO_GATE_BIT]),
    .cfg_in(irq_cfg1_in),
    .irq_out(irq1)
  );

  // merge both sources onto host levels, straight from flops
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq_out <= '0;
    end else if (clk_en_in) begin
      irq_out <= irq0 | irq1;
    end
  end
endmodule
`default_nettype wire

// File: bench/dgpio_top_sva.sv
// checker: bus answer timing, window decode, reset state and interrupt pulses of the io block
`default_nettype none
module dgpio_top_sva
  import dgpio_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [5:0] base_select_switch_in,
  input wire dgpio_bus_req_t bus_req_in,
  input wire dgpio_irq_cfg_t irq_cfg0_in,
  input wire dgpio_irq_cfg_t irq_cfg1_in,
  input wire logic [47:0] pin_in,
  input wire logic [47:0] pin_out,
  input wire logic [47:0] pin_oe_n_out,
  input wire logic [5:0] buf_dir_out,
  input wire logic [5:0] buf_gate_out,
  input wire logic [7:0] rdata_out,
  input wire logic rdata_valid_out,
  input wire logic sel_out,
  input wire logic [7:2] irq_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic hit; // a request lands inside the window this cycle
  assign hit = clk_en_in && (bus_req_in.addr[9:4] == base_select_switch_in);
  AST_RD_ANSWER: assert property (hit && bus_req_in.rd |=> rdata_valid_out)
    else $error("read inside the window not answered next cycle");
  AST_MISS_SILENT: assert property (!hit && bus_req_in.rd |=> !rdata_valid_out && !sel_out)
    else $error("read outside the window was answered");
  AST_WO_READ: assert property (hit && bus_req_in.rd && (bus_req_in.addr[3:0] inside {4'h3, 4'h7,
    4'h8, 4'h9}) |=> rdata_out == DGPIO_UNDEF_READ)
    else $error("write-only location read back register contents");
  AST_RESET_STATE: assert property (disable iff (1'b0) sys_rst_in |=> (&pin_oe_n_out) &&
    buf_dir_out == 6'h00 && buf_gate_out == 6'h00)
    else $error("reset left a port driving or buffer registers set");
  AST_PULSE_ONE: assert property (irq_out != 6'h00 |=> irq_out == 6'h00)
    else $error("interrupt pulse longer than one cycle");
  AST_OFF_QUIET: assert property ((irq_cfg0_in.mode == DGPIO_MODE_OFF &&
    irq_cfg1_in.mode == DGPIO_MODE_OFF) [*5] |-> irq_out == 6'h00)
    else $error("interrupt raised with both sources off");
  AST_NO_GATE_NO_DRIVE: assert property (!buf_gate_out[0] [*2] |-> pin_oe_n_out[7:0] == 8'hff)
    else $error("tri-stated port still driven");
  AST_RISE_FIRES: assert property ($rose(pin_in[16]) && irq_cfg0_in.mode == DGPIO_MODE_ON &&
    !irq_cfg0_in.falling |-> ##[3:5] irq_out[irq_cfg0_in.level])
    else $error("rising edge on source 0 gave no pulse");
  AST_FALL_FIRES: assert property ($fell(pin_in[16]) && irq_cfg0_in.mode == DGPIO_MODE_ON &&
    irq_cfg0_in.falling |-> ##[3:5] irq_out[irq_cfg0_in.level])
    else $error("falling edge on source 0 gave no pulse");
endmodule
bind dgpio_top dgpio_top_sva dgpio_top_sva_inst (.ref_clk_in, .sys_rst_in, .clk_en_in,
  .base_select_switch_in, .bus_req_in, .irq_cfg0_in, .irq_cfg1_in, .pin_in, .pin_out,
  .pin_oe_n_out, .buf_dir_out, .buf_gate_out, .rdata_out, .rdata_valid_out, .sel_out, .irq_out);
`default_nettype wire

// File: bench/dgpio_host_model.sv
// host model: one-cycle i/o strobes into the device window and read data capture
`default_nettype none
module dgpio_host_model
  import dgpio_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rdata_valid_in,
  output var dgpio_bus_req_t req_out
);
  // idle bus parks at 3ff, which falls inside the window only when the base is 3f0
  initial req_out = '{addr: 10'h3ff, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
  // one access: drive after a falling edge, strobe spans exactly one rising edge
  task automatic cyc(input logic [9:0] addr, input logic wr, input logic [7:0] wdata,
                     output logic [7:0] data, output logic valid);
    @(negedge ref_clk_in);
    req_out = '{addr: addr, wr: wr, rd: !wr, wdata: wdata};
    @(negedge ref_clk_in);
    // released lines show the inverse so a stale value never looks valid
    req_out = '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~wdata};
    valid = rdata_valid_in;
    data = rdata_in;
  endtask
endmodule
`default_nettype wire

// File: bench/dgpio_tb_top.sv
// testbench: drives the io block through the host model and the pins, judges its ports
`default_nettype none
module dgpio_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dgpio_pkg::*;
  logic ref_clk_in, sys_rst_in, clk_en_in, rdata_valid_out, sel_out, v;
  logic [5:0] base_select_switch_in, buf_dir_out, buf_gate_out;
  logic [47:0] pin_in, pin_out, pin_oe_n_out;
  logic [7:0] rdata_out, d;
  logic [7:2] irq_out;
  dgpio_irq_cfg_t irq_cfg0_in, irq_cfg1_in;
  dgpio_bus_req_t bus_req_in;
  int n_errors, samples_checked, cyc_count;
  localparam dgpio_irq_cfg_t OFF = '{3'h2, 1'b0, DGPIO_MODE_OFF};
  localparam dgpio_irq_cfg_t G3 = '{3'h3, 1'b0, DGPIO_MODE_GATED};
  dgpio_top dgpio_top_inst (.ref_clk_in, .sys_rst_in, .clk_en_in, .base_select_switch_in,
    .bus_req_in, .irq_cfg0_in, .irq_cfg1_in, .pin_in, .pin_out, .pin_oe_n_out, .buf_dir_out,
    .buf_gate_out, .rdata_out, .rdata_valid_out, .sel_out, .irq_out);
  dgpio_host_model dgpio_host_model_inst (.ref_clk_in, .rdata_in(rdata_out),
    .rdata_valid_in(rdata_valid_out), .req_out(bus_req_in));
  // compare and count
  task chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // access at an offset of the current window
  task acc(input logic [3:0] off, input logic wr, input logic [7:0] wd);
    dgpio_host_model_inst.cyc({base_select_switch_in, off}, wr, wd, d, v);
  endtask
  task rd_chk(input string nm, input logic [3:0] off, input logic [7:0] exp);
    acc(off, 1'b0, 8'h00);
    chk(nm, {39'h0, 1'b1, exp}, {39'h0, v, d});
  endtask
  task t_reset;
    chk("reset state", {48'hffffffffffff}, pin_oe_n_out);
    chk("reset dir gate", 48'h0, {36'h0, buf_dir_out, buf_gate_out});
  endtask
  task t_decode;
    dgpio_host_model_inst.cyc(10'h310, 1'b0, 8'h00, d, v);
    chk("miss answered", 48'h0, {47'h0, v});
    for (int o = 3; o < 16; o++) if (o == 3 || o > 6) rd_chk("undefined read", o[3:0], 8'hff);
    pin_in[7:0] = 8'h81;
    rd_chk("a0 live", 4'h0, 8'h81);
    pin_in[7:0] = 8'h3c;
    rd_chk("a0 live again", 4'h0, 8'h3c);
    pin_in[39:32] = 8'h96;
    rd_chk("b1 live", 4'h5, 8'h96);
  endtask
  // set jumpers, let them settle, move one pin and count pulses on the routed level
  task irq_try(input string nm, input dgpio_irq_cfg_t c0, input dgpio_irq_cfg_t c1,
               input int b, input logic lv, input int exp);
    int n;
    n = 0;
    irq_cfg0_in = c0;
    irq_cfg1_in = c1;
    repeat (6) @(negedge ref_clk_in);
    pin_in[b] = lv;
    repeat (8) begin
      @(negedge ref_clk_in);
      n += int'(irq_out[(b < 24) ? c0.level : c1.level] === 1'b1);
    end
    chk(nm, 48'(exp), 48'(n));
  endtask
  task t_irq;
    irq_try("rise on", '{3'h3, 1'b0, DGPIO_MODE_ON}, OFF, 16, 1'b1, 1);
    irq_try("fall in rise mode", '{3'h3, 1'b0, DGPIO_MODE_ON}, OFF, 16, 1'b0, 0);
    irq_try("rise in fall mode", '{3'h7, 1'b1, DGPIO_MODE_ON}, OFF, 16, 1'b1, 0);
    irq_try("fall on", '{3'h7, 1'b1, DGPIO_MODE_ON}, OFF, 16, 1'b0, 1);
    irq_try("off", OFF, OFF, 16, 1'b1, 0);
    irq_try("gate up", G3, OFF, 20, 1'b1, 0);
    irq_try("src low", G3, OFF, 16, 1'b0, 0);
    irq_try("rise gated off", G3, OFF, 16, 1'b1, 0);
    irq_try("gate down", G3, OFF, 20, 1'b0, 0);
    irq_try("src low again", G3, OFF, 16, 1'b0, 0);
    irq_try("rise gated on", G3, OFF, 16, 1'b1, 1);
    irq_try("src1 gated on", OFF, '{3'h2, 1'b0, DGPIO_MODE_GATED}, 40, 1'b1, 1);
  endtask
  task t_output;
    acc(4'h3, 1'b1, 8'h00);
    acc(4'h8, 1'b1, 8'h3f);
    acc(4'h9, 1'b1, 8'h3f);
    acc(4'h0, 1'b1, 8'h5a);
    @(negedge ref_clk_in);
    chk("bad tag keeps input", 48'hff, 48'(pin_oe_n_out[7:0]));
    acc(4'h3, 1'b1, 8'h80);
    @(negedge ref_clk_in);
    chk("group0 drives", 48'h5a, {pin_oe_n_out[23:0], 16'h0, pin_out[7:0]});
    pin_in[7:0] = 8'h0f;
    rd_chk("a0 readback", 4'h0, 8'h5a);
    acc(4'h3, 1'b1, 8'h89);
    @(negedge ref_clk_in);
    chk("c0 whole input", 48'hff, 48'(pin_oe_n_out[23:16]));
    acc(4'h3, 1'b1, 8'h81);
    @(negedge ref_clk_in);
    chk("c0 low bit ignored", 48'h0, 48'(pin_oe_n_out[23:16]));
    acc(4'h7, 1'b1, 8'h80);
    acc(4'h4, 1'b1, 8'ha5);
    @(negedge ref_clk_in);
    chk("a1 drives", 48'ha500, 48'({pin_out[31:24], pin_oe_n_out[31:24]}));
    acc(4'h9, 1'b1, 8'h3e);
    acc(4'h8, 1'b1, 8'h1f);
    @(negedge ref_clk_in);
    chk("tri-state and receive", 48'hffff, 48'({pin_oe_n_out[7:0], pin_oe_n_out[31:24]}));
    chk("dir gate copy", 48'h7fe, 48'({buf_dir_out, buf_gate_out}));
  endtask
  task t_base;
    base_select_switch_in = 6'h00;
    rd_chk("base 000", 4'h4, 8'ha5);
    base_select_switch_in = 6'h3f;
    rd_chk("base 3f0", 4'h4, 8'ha5);
    clk_en_in = 1'b0;
    acc(4'h4, 1'b1, 8'h00);
    clk_en_in = 1'b1;
    rd_chk("frozen write ignored", 4'h4, 8'ha5);
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // free-running clock
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  // hang guard
  always @(posedge ref_clk_in) begin
    cyc_count++;
    if (cyc_count == 5000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  // main sequence
  initial begin
    n_errors = 0;
    samples_checked = 0;
    cyc_count = 0;
    sys_rst_in = 1'b1;
    clk_en_in = 1'b1;
    base_select_switch_in = DGPIO_BASE_DEFAULT;
    pin_in = '0;
    irq_cfg0_in = OFF;
    irq_cfg1_in = OFF;
    repeat (3) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    t_reset;
    t_decode;
    t_irq;
    t_output;
    t_base;
    tally_and_finish;
  end
endmodule
`default_nettype wire
